/* File: design/stsb_pkg.sv */
package stsb_pkg;

  // 7-bit register addresses carried in the first frame byte
  localparam logic [6:0] ADDR_SCRATCH = 7'h1e;
  localparam logic [6:0] ADDR_SUP_B   = 7'h40;
  localparam logic [6:0] ADDR_SUP_A   = 7'h41;
  localparam logic [6:0] ADDR_THERM   = 7'h42;

  // frame layout: address in bits 6:0, access bit 7, data in bits 15:8
  localparam int unsigned FRAME_BITS     = 16;
  localparam int unsigned FRAME_ADDR_LEN = 8;

  // supply_fail_status_b field positions
  localparam int unsigned SB_BATTERY_LOW  = 6;
  localparam int unsigned SB_REG3_OC      = 4;
  localparam int unsigned SB_REG3_UV      = 3;
  localparam int unsigned SB_REG3_OT      = 2;
  localparam int unsigned SB_MAIN_OV      = 1;
  localparam int unsigned SB_MAIN_PREWARN = 0;

  // supply_fail_status_a field positions
  localparam int unsigned SA_POR         = 7;
  localparam int unsigned SA_SW_LOW      = 6;
  localparam int unsigned SA_SW_HIGH     = 5;
  localparam int unsigned SA_REG2_OT     = 4;
  localparam int unsigned SA_REG2_UV     = 3;
  localparam int unsigned SA_MAIN_SHORT  = 2;
  localparam int unsigned SA_MAIN_FS_UV  = 1;
  localparam int unsigned SA_MAIN_UV     = 0;

  // thermal_protect_status field positions
  localparam int unsigned TH_SHUT2   = 2;
  localparam int unsigned TH_SHUT1   = 1;
  localparam int unsigned TH_PREWARN = 0;

  // implemented bits; the rest are reserved and read zero
  localparam logic [7:0] SUP_B_MASK = 8'h5f;
  localparam logic [7:0] SUP_A_MASK = 8'hff;
  localparam logic [7:0] THERM_MASK = 8'h07;

  // reset values
  localparam logic [7:0] SCRATCH_POR = 8'h00;
  localparam logic [7:0] SUP_B_RST   = 8'h00;
  localparam logic [7:0] SUP_A_POR   = 8'h80;
  localparam logic [7:0] SUP_A_SOFT  = 8'h00;
  localparam logic [7:0] THERM_RST   = 8'h00;

  // timing
  localparam int unsigned CLK_FREQ_KHZ     = 10000;
  localparam int unsigned SHORT_TIME_MS    = 4;
  localparam int unsigned SHORT_CYCLES     = SHORT_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned UV_FAILSAFE_CNT  = 4;

  typedef enum logic [2:0] {
    STSB_MODE_INIT,
    STSB_MODE_NORMAL,
    STSB_MODE_STOP,
    STSB_MODE_SLEEP,
    STSB_MODE_RESTART,
    STSB_MODE_FAILSAFE
  } stsb_mode_type;

  typedef struct packed {
    logic battery_low;
    logic reg3_overcurrent;
    logic reg3_undervoltage;
    logic reg3_overtemp;
    logic main_reg_overvoltage;
    logic main_reg_prewarn;
    logic switch_supply_low;
    logic switch_supply_high;
    logic reg2_overtemp;
    logic reg2_undervoltage;
    logic thermal_prewarning;
    logic thermal_shutdown_level1;
    logic thermal_shutdown_level2;
  } stsb_event_type;

  typedef struct packed {
    logic [7:0] data;
    logic       access;
    logic [6:0] addr;
  } stsb_frame_type;

endpackage

/* File: design/stsb_spi_frame.sv */
`timescale 1ns/100ps
module stsb_spi_frame (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    spi_sck_i,
  input  wire logic                    spi_csn_i,
  input  wire logic                    spi_mosi_i,
  input  wire logic [7:0]              tx_data_i,
  output logic                         spi_miso_o,
  output logic [6:0]                   addr_o,
  output stsb_pkg::stsb_frame_type     frame_o,
  output logic                         frame_done_o
);
  import stsb_pkg::*;

  logic        sck_q;
  logic        csn_q;
  logic [4:0]  bit_cnt;
  logic [15:0] rx;
  logic [6:0]  tx_sh;

  localparam logic [4:0] CNT_FULL = 5'(FRAME_BITS);
  localparam logic [4:0] CNT_ADDR = 5'(FRAME_ADDR_LEN);

  wire sck_rise    = spi_sck_i & ~sck_q & ~spi_csn_i;
  wire sck_fall    = ~spi_sck_i & sck_q & ~spi_csn_i;
  wire frame_start = ~spi_csn_i & csn_q;
  wire frame_end   = spi_csn_i & ~csn_q;

  assign addr_o = rx[6:0];

  // lsb first, sampled on sck rise, shifted out on sck fall
  // bit count saturates one past full so long frames are dropped
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sck_q        <= 1'b0;
      csn_q        <= 1'b1;
      bit_cnt      <= 5'h00;
      rx           <= 16'h0000;
      tx_sh        <= 7'h00;
      spi_miso_o   <= 1'b0;
      frame_o      <= '0;
      frame_done_o <= 1'b0;
    end else begin
      sck_q        <= spi_sck_i;
      csn_q        <= spi_csn_i;
      frame_done_o <= 1'b0;
      if (frame_start) begin
        bit_cnt    <= 5'h00;
        tx_sh      <= 7'h00;
        spi_miso_o <= 1'b0;
      end else if (sck_rise) begin
        if (bit_cnt < CNT_FULL) begin
          rx[bit_cnt[3:0]] <= spi_mosi_i; // [RULE5] [RULE6]
        end
        if (bit_cnt <= CNT_FULL) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end else if (sck_fall) begin
        if (bit_cnt == CNT_ADDR) begin
          spi_miso_o <= tx_data_i[0]; // [RULE6]
          tx_sh      <= tx_data_i[7:1];
        end else begin
          spi_miso_o <= tx_sh[0];
          tx_sh      <= {1'b0, tx_sh[6:1]};
        end
      end
      if (frame_end && bit_cnt == CNT_FULL) begin
        frame_o      <= rx; // [RULE5]
        frame_done_o <= 1'b1;
      end
    end
  end

endmodule

/* File: design/stsb_bank.sv */
// Overview of operation
// [RULE1] host scratch byte, zero at power-up, unused internally
// [RULE2] scratch byte survives soft reset
// [RULE3] scratch reachable only in normal mode
// [RULE4] mode transitions never clear scratch byte
// [RULE5] frame: 7-bit address, access bit, data byte
// [RULE6] data bits D0..D7 sit at frame 8..15
// [RULE7] access bit zero reads without altering
// [RULE8] access bit one clears whole status byte
// [RULE9] status flags sticky until host clears
// [RULE10] reserved status bits always read zero
// [RULE11] supply b flags set on detection
// [RULE12] supply a regulator and switch flags set
// [RULE13] power-on flag 0x80 at por, soft reset zero
// [RULE14] short flag after over 4 ms low
// [RULE15] flag failsafe entry on fourth undervoltage reset
// [RULE16] undervoltage flag update gated by mode
// [RULE17] no main regulator flags while off in sleep; main_reg_prewarn and uv_fourth still set their flags there
// [RULE18] thermal flags set, level two forces failsafe
// [RULE19] thermal flags held until host clears
`timescale 1ns/100ps
module stsb_bank #(
  parameter int unsigned SHORT_CYCLES_P = stsb_pkg::SHORT_CYCLES
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    soft_reset_i,
  input  wire stsb_pkg::stsb_mode_type mode_i,
  input  wire stsb_pkg::stsb_event_type events_i,
  input  wire logic                    main_reg_on_i,
  input  wire logic                    main_below_reset_i,
  input  wire logic                    main_uv_reset_i,
  input  wire logic                    reset_output_released_i,
  input  wire logic                    spi_sck_i,
  input  wire logic                    spi_csn_i,
  input  wire logic                    spi_mosi_i,
  output logic                         spi_miso_o,
  output logic                         failsafe_request_o
);
  import stsb_pkg::*;

  localparam logic [15:0] SHORT_LIMIT = 16'(SHORT_CYCLES_P);
  localparam logic [2:0]  UV_LAST     = 3'(UV_FAILSAFE_CNT - 1);

  logic [7:0]     host_scratch_value;
  logic [7:0]     sup_b;
  logic [7:0]     sup_a;
  logic [7:0]     therm;
  logic           rst_out_seen;
  logic [15:0]    short_cnt;
  logic [2:0]     uv_cnt;
  logic [7:0]     rd_data;
  logic [6:0]     cur_addr;
  stsb_frame_type frame;
  logic           frame_done;

  logic [7:0]     set_b;
  logic [7:0]     set_a;
  logic [7:0]     set_t;
  logic [7:0]     next_sup_b;
  logic [7:0]     next_sup_a;
  logic [7:0]     next_therm;
  logic [7:0]     next_scratch;
  logic [15:0]    next_short_cnt;
  logic [2:0]     next_uv_cnt;

  stsb_spi_frame u_frame (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n_i),
    .spi_sck_i    (spi_sck_i),
    .spi_csn_i    (spi_csn_i),
    .spi_mosi_i   (spi_mosi_i),
    .tx_data_i    (rd_data),
    .spi_miso_o   (spi_miso_o),
    .addr_o       (cur_addr),
    .frame_o      (frame),
    .frame_done_o (frame_done)
  );

  // mode decode
  wire in_init     = (mode_i == STSB_MODE_INIT);
  wire in_normal   = (mode_i == STSB_MODE_NORMAL);
  wire in_stop     = (mode_i == STSB_MODE_STOP);
  wire in_sleep    = (mode_i == STSB_MODE_SLEEP);
  wire in_restart  = (mode_i == STSB_MODE_RESTART);

  // access decode at the end of a complete frame
  wire clear_cmd   = frame_done & frame.access; // [RULE5] [RULE8]
  wire hit_scratch = (frame.addr == ADDR_SCRATCH);
  wire clr_b       = clear_cmd & (frame.addr == ADDR_SUP_B);
  wire clr_a       = clear_cmd & (frame.addr == ADDR_SUP_A);
  wire clr_t       = clear_cmd & (frame.addr == ADDR_THERM);
  wire wr_scratch  = clear_cmd & hit_scratch & in_normal; // [RULE3]

  // main regulator off in sleep masks its comparators
  wire main_off_sleep = in_sleep & ~main_reg_on_i; // [RULE17]

  // short detection: low for the whole window after switch-on
  wire short_run  = main_reg_on_i & main_below_reset_i;
  wire short_cond = short_run & (short_cnt == SHORT_LIMIT); // [RULE14]

  // a short overrides the mode gating, restart included
  wire uv_update = ~main_off_sleep &
                   ((in_init & rst_out_seen) | in_normal | in_stop | short_cond); // [RULE16]

  wire uv_fourth = main_uv_reset_i & (uv_cnt == UV_LAST); // [RULE15]

  assign next_short_cnt = !short_run ? 16'h0000 :
                          (short_cnt == SHORT_LIMIT) ? short_cnt :
                          short_cnt + 16'h0001;

  assign next_uv_cnt = in_normal ? 3'h0 :
                       (main_uv_reset_i && uv_cnt < UV_LAST) ? uv_cnt + 3'h1 :
                       uv_cnt;

  // supply b detections
  assign set_b[7]               = 1'b0;
  assign set_b[SB_BATTERY_LOW]  = events_i.battery_low; // [RULE11]
  assign set_b[5]               = 1'b0;
  assign set_b[SB_REG3_OC]      = events_i.reg3_overcurrent; // [RULE11]
  assign set_b[SB_REG3_UV]      = events_i.reg3_undervoltage; // [RULE11]
  assign set_b[SB_REG3_OT]      = events_i.reg3_overtemp; // [RULE11]
  assign set_b[SB_MAIN_OV]      = events_i.main_reg_overvoltage & ~main_off_sleep; // [RULE17]
  assign set_b[SB_MAIN_PREWARN] = events_i.main_reg_prewarn; // [RULE11]

  // supply a detections
  assign set_a[SA_POR]         = 1'b0;
  assign set_a[SA_SW_LOW]      = events_i.switch_supply_low; // [RULE12]
  assign set_a[SA_SW_HIGH]     = events_i.switch_supply_high; // [RULE12]
  assign set_a[SA_REG2_OT]     = events_i.reg2_overtemp; // [RULE12]
  assign set_a[SA_REG2_UV]     = events_i.reg2_undervoltage; // [RULE12]
  assign set_a[SA_MAIN_SHORT]  = short_cond & ~main_off_sleep; // [RULE14] [RULE17]
  assign set_a[SA_MAIN_FS_UV]  = uv_fourth; // [RULE15]
  assign set_a[SA_MAIN_UV]     = main_below_reset_i & uv_update; // [RULE16]

  // thermal detections
  assign set_t[7:3]        = 5'h00;
  assign set_t[TH_SHUT2]   = events_i.thermal_shutdown_level2; // [RULE18]
  assign set_t[TH_SHUT1]   = events_i.thermal_shutdown_level1; // [RULE18]
  assign set_t[TH_PREWARN] = events_i.thermal_prewarning; // [RULE18]

  // a detection in the clearing cycle wins over the clear
  assign next_sup_b = ((sup_b & ~{8{clr_b}}) | set_b) & SUP_B_MASK; // [RULE8] [RULE9] [RULE10]
  assign next_sup_a = ((sup_a & ~{8{clr_a}}) | set_a) & SUP_A_MASK; // [RULE8] [RULE9]
  assign next_therm = ((therm & ~{8{clr_t}}) | set_t) & THERM_MASK; // [RULE8] [RULE19] [RULE10]

  assign next_scratch = wr_scratch ? frame.data : host_scratch_value; // [RULE6]

  // read mux; the address byte is complete when the data byte starts
  always_comb begin
    if (cur_addr == ADDR_SCRATCH) begin
      rd_data = in_normal ? host_scratch_value : 8'h00; // [RULE3]
    end else if (cur_addr == ADDR_SUP_B) begin
      rd_data = sup_b; // [RULE7]
    end else if (cur_addr == ADDR_SUP_A) begin
      rd_data = sup_a; // [RULE7]
    end else if (cur_addr == ADDR_THERM) begin
      rd_data = therm; // [RULE7]
    end else begin
      rd_data = 8'h00;
    end
  end

  // only power-on reset and a host write in normal mode touch the scratch byte; modes never do
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      host_scratch_value <= SCRATCH_POR; // [RULE1]
    end else begin
      host_scratch_value <= next_scratch; // [RULE2] [RULE4]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sup_b <= SUP_B_RST;
      sup_a <= SUP_A_POR; // [RULE13]
      therm <= THERM_RST;
    end else if (soft_reset_i) begin
      sup_b <= SUP_B_RST;
      sup_a <= SUP_A_SOFT; // [RULE13]
      therm <= THERM_RST;
    end else begin
      sup_b <= next_sup_b;
      sup_a <= next_sup_a;
      therm <= next_therm;
    end
  end

  // first release of the reset output during init
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rst_out_seen <= 1'b0;
    end else if (in_restart) begin
      rst_out_seen <= 1'b0;
    end else if (in_init && reset_output_released_i) begin
      rst_out_seen <= 1'b1; // [RULE16]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      short_cnt          <= 16'h0000;
      uv_cnt             <= 3'h0;
      failsafe_request_o <= 1'b0;
    end else begin
      short_cnt          <= next_short_cnt;
      uv_cnt             <= next_uv_cnt;
      failsafe_request_o <= uv_fourth | events_i.thermal_shutdown_level2; // [RULE18] [RULE15]
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_scratch_write;
    frame_done && frame.access && hit_scratch;
  endsequence

  sequence s_quiet_cycle;
    !soft_reset_i;
  endsequence

  a_scratch_soft_keep: assert property ( // [RULE2]
    soft_reset_i && !wr_scratch |=> host_scratch_value == $past(host_scratch_value))
    else $error("scratch byte changed on soft reset");

  a_scratch_mode_gate: assert property ( // [RULE3]
    s_scratch_write ##0 !in_normal |=> $stable(host_scratch_value))
    else $error("scratch byte written outside normal mode");

  a_scratch_write_data: assert property ( // [RULE6]
    s_scratch_write ##0 in_normal |=> host_scratch_value == $past(frame.data))
    else $error("scratch byte did not take frame data");

  a_status_read_keep: assert property ( // [RULE7]
    frame_done && !frame.access ##0 s_quiet_cycle
    |=> (sup_a & $past(sup_a)) == $past(sup_a) && (therm & $past(therm)) == $past(therm))
    else $error("read access altered a status byte");

  a_status_clear_byte: assert property ( // [RULE8]
    clr_t && set_t == 8'h00 ##0 s_quiet_cycle |=> therm == 8'h00)
    else $error("clear access left thermal bits set");

  a_flags_sticky: assert property ( // [RULE9]
    !clr_b && !soft_reset_i |=> (sup_b & $past(sup_b)) == $past(sup_b))
    else $error("supply flag dropped without clear");

  a_reserved_zero: assert property ( // [RULE10]
    (sup_b & ~SUP_B_MASK) == 8'h00 && (therm & ~THERM_MASK) == 8'h00)
    else $error("reserved status bit set");

  a_por_soft_clear: assert property ( // [RULE13]
    soft_reset_i |=> sup_a == SUP_A_SOFT)
    else $error("soft reset left supply a non zero");

  a_short_flag_set: assert property ( // [RULE14]
    short_cond && !main_off_sleep ##0 s_quiet_cycle |=> sup_a[SA_MAIN_SHORT])
    else $error("short held past window but flag not set");

  a_short_not_early: assert property ( // [RULE14]
    $rose(short_run) && !sup_a[SA_MAIN_SHORT] |=> !sup_a[SA_MAIN_SHORT] [*2])
    else $error("short flag set before the window elapsed");

  a_uv_fourth_flag: assert property ( // [RULE15]
    uv_fourth ##0 s_quiet_cycle |=> sup_a[SA_MAIN_FS_UV] && failsafe_request_o)
    else $error("fourth undervoltage reset not flagged");

  a_uv_restart_hold: assert property ( // [RULE16]
    in_restart && !short_cond && !sup_a[SA_MAIN_UV] |=> !sup_a[SA_MAIN_UV])
    else $error("undervoltage flag updated in restart mode");

  a_sleep_no_set: assert property ( // [RULE17]
    main_off_sleep && !sup_b[SB_MAIN_OV] && !sup_a[SA_MAIN_SHORT]
    |=> !sup_b[SB_MAIN_OV] && !sup_a[SA_MAIN_SHORT])
    else $error("main regulator flag set while off in sleep");

  a_shutdown_failsafe: assert property ( // [RULE18]
    events_i.thermal_shutdown_level2 ##0 s_quiet_cycle |=> failsafe_request_o && therm[TH_SHUT2])
    else $error("level two shutdown did not force failsafe");

  a_thermal_hold: assert property ( // [RULE19]
    therm[TH_SHUT1] && !clr_t && !soft_reset_i |=> therm[TH_SHUT1])
    else $error("thermal flag cleared without host command");

  sequence s_mode_updates_uv;
    main_below_reset_i && (in_normal || in_stop);
  endsequence

  sequence s_short_held;
    short_cond && !main_off_sleep;
  endsequence

  a_reset_values: assert property ( // [RULE1] [RULE13]
    $rose(rst_n_i) |-> host_scratch_value == SCRATCH_POR && sup_a == SUP_A_POR)
    else $error("register not at power-on value after reset");

  a_scratch_hold: assert property ( // [RULE4]
    !wr_scratch |=> $stable(host_scratch_value))
    else $error("scratch byte changed without a host write");

  a_scratch_read_gate: assert property ( // [RULE3]
    cur_addr == ADDR_SCRATCH && !in_normal |-> rd_data == 8'h00)
    else $error("scratch byte readable outside normal mode");

  a_fail_cause: assert property ( // [RULE15] [RULE18]
    failsafe_request_o |-> $past(uv_fourth) || $past(events_i.thermal_shutdown_level2))
    else $error("failsafe request without a cause");

  a_therm_sticky: assert property ( // [RULE19]
    !clr_t && !soft_reset_i |=> (therm & $past(therm)) == $past(therm))
    else $error("thermal flag dropped without clear");

  a_supply_a_sticky: assert property ( // [RULE9]
    !clr_a && !soft_reset_i |=> (sup_a & $past(sup_a)) == $past(sup_a))
    else $error("supply a flag dropped without clear");

  a_clear_supply_a: assert property ( // [RULE8]
    clr_a && set_a == 8'h00 ##0 s_quiet_cycle |=> sup_a == 8'h00)
    else $error("clear access left supply a bits set");

  a_clear_supply_b: assert property ( // [RULE8]
    clr_b && set_b == 8'h00 ##0 s_quiet_cycle |=> sup_b == 8'h00)
    else $error("clear access left supply b bits set");

  a_uv_init_gate: assert property ( // [RULE16]
    in_init && !rst_out_seen && !short_cond && !sup_a[SA_MAIN_UV] |=> !sup_a[SA_MAIN_UV])
    else $error("undervoltage flag set in init before release");

  a_uv_normal_set: assert property ( // [RULE16]
    s_mode_updates_uv ##0 s_quiet_cycle |=> sup_a[SA_MAIN_UV])
    else $error("undervoltage in normal or stop not flagged");

  a_uv_short_set: assert property ( // [RULE16]
    s_short_held ##0 s_quiet_cycle |=> sup_a[SA_MAIN_UV])
    else $error("undervoltage during short not flagged");

  a_battery_low_set: assert property ( // [RULE11]
    events_i.battery_low ##0 s_quiet_cycle |=> sup_b[SB_BATTERY_LOW])
    else $error("battery low event not flagged");

  a_switch_low_set: assert property ( // [RULE12]
    events_i.switch_supply_low ##0 s_quiet_cycle |=> sup_a[SA_SW_LOW])
    else $error("switch supply low event not flagged");

endmodule

/* File: verification/stsb_host_model.sv */
`timescale 1ns/100ps
module stsb_host_model (
  input  wire logic clk_sys_i,
  input  wire logic spi_miso_i,
  output logic      spi_sck_o,
  output logic      spi_csn_o,
  output logic      spi_mosi_o
);
  // sck phase length in clocks; the bench raises it to act as a slow host
  int hold = 3;

  initial begin
    spi_sck_o = 1'b0;
    spi_csn_o = 1'b1;
    spi_mosi_o = 1'b0;
  end

  // idle data line keeps toggling so a stale bit never passes for data
  always @(negedge clk_sys_i) begin
    if (spi_csn_o) begin
      spi_mosi_o <= ~spi_mosi_o;
    end
  end

  // one 16-bit frame, lsb first, sck idle low
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    spi_csn_o = 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_sys_i);
      spi_mosi_o = w[i];
      repeat (hold - 1) @(negedge clk_sys_i);
      if (i >= 8) rd[i-8] = spi_miso_i;
      spi_sck_o = 1'b1;
      repeat (hold) @(negedge clk_sys_i);
      spi_sck_o = 1'b0;
    end
    repeat (hold) @(negedge clk_sys_i);
    spi_csn_o = 1'b1;
    // gap covers the two edges the register needs to take effect
    repeat (4) @(negedge clk_sys_i);
  endtask
endmodule

/* File: verification/stsb_bank_tb.sv */
`timescale 1ns/100ps
module stsb_bank_tb;
  import stsb_pkg::*;
  localparam int unsigned SHORT_P = 20;
  logic           clk_sys_i;
  logic           rst_n_i;
  logic           soft_reset_i;
  logic           main_reg_on_i;
  logic           main_below_reset_i;
  logic           main_uv_reset_i;
  logic           reset_output_released_i;
  logic           spi_sck;
  logic           spi_csn;
  logic           spi_mosi;
  logic           spi_miso;
  logic           failsafe_request;
  stsb_mode_type  mode_i;
  stsb_event_type events_i;
  int             err_count;
  int             n_checks;
  logic [7:0]     rd;
  logic [7:0]     val;
  logic [12:0]    e;
  logic [6:0]     sa [3];
  logic [7:0]     x [3];
  logic [7:0]     ua [6];
  stsb_mode_type  um [6];

  stsb_bank #(.SHORT_CYCLES_P(SHORT_P)) uut (
    .clk_sys_i              (clk_sys_i),
    .rst_n_i                (rst_n_i),
    .soft_reset_i           (soft_reset_i),
    .mode_i                 (mode_i),
    .events_i               (events_i),
    .main_reg_on_i          (main_reg_on_i),
    .main_below_reset_i     (main_below_reset_i),
    .main_uv_reset_i        (main_uv_reset_i),
    .reset_output_released_i(reset_output_released_i),
    .spi_sck_i              (spi_sck),
    .spi_csn_i              (spi_csn),
    .spi_mosi_i             (spi_mosi),
    .spi_miso_o             (spi_miso),
    .failsafe_request_o     (failsafe_request)
  );

  stsb_host_model host (
    .clk_sys_i (clk_sys_i),
    .spi_miso_i(spi_miso),
    .spi_sck_o (spi_sck),
    .spi_csn_o (spi_csn),
    .spi_mosi_o(spi_mosi)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [7:0] exp_b(input logic [12:0] v);
    return {1'b0, v[12], 1'b0, v[11:7]};
  endfunction
  function automatic logic [7:0] exp_a(input logic [12:0] v);
    return {1'b0, v[6:3], 3'b000};
  endfunction
  function automatic logic [7:0] exp_t(input logic [12:0] v);
    return {5'b00000, v[0], v[1], v[2]};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic chk(input logic [6:0] a, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t addr %h got %h exp %h", $time, a, got, exp);
    end
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    host.xfer({8'h00, 1'b0, a}, rd);
    chk(a, rd, exp);
  endtask

  // access bit one: write on the scratch byte, clear on a status byte
  task automatic acc(input logic [6:0] a, input logic [7:0] d);
    host.xfer({d, 1'b1, a}, rd);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    cyc(90000);
    err_count++;
    $display("MISMATCH t=%0t run limit reached", $time);
    print_verdict();
  end

  initial begin
    err_count = 0;
    n_checks = 0;
    rst_n_i = 1'b0;
    soft_reset_i = 1'b0;
    mode_i = STSB_MODE_NORMAL;
    events_i = '0;
    main_reg_on_i = 1'b1;
    main_below_reset_i = 1'b0;
    main_uv_reset_i = 1'b0;
    reset_output_released_i = 1'b1;
    sa = '{ADDR_SUP_B, ADDR_SUP_A, ADDR_THERM};
    ua = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h05, 8'h00};
    um = '{STSB_MODE_RESTART, STSB_MODE_INIT, STSB_MODE_INIT,
           STSB_MODE_NORMAL, STSB_MODE_NORMAL, STSB_MODE_SLEEP};
    void'($urandom(32'hfe065f0b));
    cyc(4);
    rst_n_i = 1'b1;
    cyc(2);
    rdchk(ADDR_SCRATCH, 8'h00);
    x = '{8'h00, 8'h80, 8'h00};
    for (int j = 0; j < 3; j++) rdchk(sa[j], x[j]);
    acc(ADDR_SUP_A, 8'h00);
    $display("test power-on values done");

    for (int k = 0; k < 17; k++) begin
      e = (k < 13) ? 13'h0001 << k : 13'($urandom);
      events_i = stsb_event_type'(e);
      cyc(2);
      chk(7'h7f, {7'h00, failsafe_request}, {7'h00, e[0]});
      events_i = '0;
      x = '{exp_b(e), exp_a(e), exp_t(e)};
      for (int j = 0; j < 3; j++) rdchk(sa[j], x[j]);
      rdchk(sa[k % 3], x[k % 3]);
      for (int j = 0; j < 3; j++) acc(sa[j], 8'($urandom));
      for (int j = 0; j < 3; j++) rdchk(sa[j], 8'h00);
    end
    $display("test status flags done");

    host.hold = 6;
    val = 8'($urandom);
    acc(ADDR_SCRATCH, val);
    rdchk(ADDR_SCRATCH, val);
    mode_i = STSB_MODE_STOP;
    acc(ADDR_SCRATCH, ~val);
    rdchk(ADDR_SCRATCH, 8'h00);
    mode_i = STSB_MODE_RESTART;
    cyc(3);
    mode_i = STSB_MODE_FAILSAFE;
    cyc(3);
    mode_i = STSB_MODE_NORMAL;
    rdchk(ADDR_SCRATCH, val);
    host.hold = 3;
    events_i = stsb_event_type'(13'h1fff);
    cyc(1);
    events_i = '0;
    soft_reset_i = 1'b1;
    cyc(1);
    soft_reset_i = 1'b0;
    rdchk(ADDR_SCRATCH, val);
    for (int j = 0; j < 3; j++) rdchk(sa[j], 8'h00);
    rst_n_i = 1'b0;
    cyc(2);
    rst_n_i = 1'b1;
    cyc(2);
    rdchk(ADDR_SCRATCH, 8'h00);
    rdchk(ADDR_SUP_A, 8'h80);
    acc(ADDR_SUP_A, 8'h00);
    acc(7'h43, 8'hff);
    rdchk(7'h43, 8'h00);
    $display("test scratch and resets done");

    for (int r = 0; r < 6; r++) begin
      mode_i = um[r];
      reset_output_released_i = (r != 1);
      main_reg_on_i = (r != 5);
      cyc(2);
      main_below_reset_i = 1'b1;
      events_i.main_reg_overvoltage = 1'b1;
      cyc(r < 3 ? 3 : (r == 3 ? SHORT_P : SHORT_P + 1));
      main_below_reset_i = 1'b0;
      events_i = '0;
      mode_i = STSB_MODE_NORMAL;
      main_reg_on_i = 1'b1;
      rdchk(ADDR_SUP_A, ua[r]);
      rdchk(ADDR_SUP_B, (r == 5) ? 8'h00 : 8'h02);
      acc(ADDR_SUP_A, 8'h00);
      acc(ADDR_SUP_B, 8'h00);
    end
    $display("test regulator flags done");

    // count is cleared in normal mode, so the pulses come in stop mode
    mode_i = STSB_MODE_STOP;
    for (int p = 1; p <= 4; p++) begin
      main_uv_reset_i = 1'b1;
      cyc(1);
      chk(7'h7f, {7'h00, failsafe_request}, (p == 4) ? 8'h01 : 8'h00);
      main_uv_reset_i = 1'b0;
      cyc(3);
      if (p >= 3) rdchk(ADDR_SUP_A, (p == 4) ? 8'h02 : 8'h00);
    end
    $display("test fail-safe entry done");
    print_verdict();
  end
endmodule
